// [adc_serial_port.sv]
`timescale 1ns/1ps

// Functional notes
// - Sample input rising, change output falling
// - Select is active low
// - Release data output within five periods
// - Stalled serial clock resets shift state
// - Result ready output is active low
// - Unread result: ready high one period
// - First bit valid before ready falls
// - Conversion start input is active high
// - Reset low two cycles restores state
module adc_serial_port
    import adc_port_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    // Serial pins
    input  wire spi_in_s             pins_i,
    output spi_out_s                 pins_o,
    // Conversion control and stall timeout length
    input  wire logic                start_i,
    input  wire logic                short_timeout_i,
    output logic                     conv_run_o,
    // Converter side
    input  wire logic [RESULT_W-1:0] result_i,
    input  wire logic                result_valid_i,
    output logic                     result_ready_n_o,
    // Received command bytes
    output logic [CMD_W-1:0]         rx_data_o,
    output logic                     rx_valid_o
);

    localparam int rel_bound = RELEASE_CYC;

    logic                sclk_q_ff;
    logic                sel_n_q_ff;
    logic [RESULT_W-1:0] tx_sr_ff;
    logic                sdo_ff;
    logic                oe_n_ff;
    logic [CMD_W-1:0]    rx_sr_ff;
    logic [BITCNT_W-1:0] bit_cnt_ff;
    logic [CMD_W-1:0]    rx_data_ff;
    logic                rx_valid_ff;
    logic                ready_n_ff;
    logic                fall_pend_ff;
    logic                run_ff;

    logic [RESULT_W-1:0] nxt_tx_sr;
    logic                nxt_sdo;
    logic                nxt_oe_n;
    logic [CMD_W-1:0]    nxt_rx_sr;
    logic [BITCNT_W-1:0] nxt_bit_cnt;
    logic [CMD_W-1:0]    nxt_rx_data;
    logic                nxt_rx_valid;
    logic                nxt_ready_n;
    logic                nxt_fall_pend;

    logic                selected;
    logic                rise_edge;
    logic                fall_edge;
    logic                stall;

    // Inputs are synchronous to clk_i, so one stage gives the edge history
    assign selected  = !pins_i.sel_n;
    assign rise_edge = selected && pins_i.sclk && !sclk_q_ff;
    assign fall_edge = selected && !pins_i.sclk && sclk_q_ff;

    sclk_stall_timer u_stall (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .armed_i     (selected),
        .sclk_edge_i (pins_i.sclk != sclk_q_ff),
        .short_i     (short_timeout_i),
        .expire_o    (stall)
    );

    always_comb begin
        nxt_tx_sr     = tx_sr_ff;
        nxt_sdo       = sdo_ff;
        nxt_rx_sr     = rx_sr_ff;
        nxt_bit_cnt   = bit_cnt_ff;
        nxt_rx_data   = rx_data_ff;
        nxt_rx_valid  = 1'b0;
        nxt_ready_n   = ready_n_ff;
        nxt_fall_pend = 1'b0;
        // Deselect takes effect at the next edge, well inside the limit
        nxt_oe_n      = pins_i.sel_n;

        // Deselected: pins_i edges never qualify, receive shift state holds
        if (rise_edge) begin
            nxt_rx_sr   = {rx_sr_ff[CMD_W-2:0], pins_i.sdi};
            nxt_bit_cnt = bit_cnt_ff + BITCNT_W'(1);
            if (bit_cnt_ff == BITCNT_TOP) begin
                nxt_rx_data  = {rx_sr_ff[CMD_W-2:0], pins_i.sdi};
                nxt_rx_valid = 1'b1;
            end
        end
        if (fall_edge) begin
            nxt_sdo   = tx_sr_ff[RESULT_W-1];
            nxt_tx_sr = {tx_sr_ff[RESULT_W-2:0], 1'b0};
            // Reading has begun, so the result counts as taken
            nxt_ready_n = 1'b1;
        end
        if (stall) begin
            nxt_bit_cnt = BITCNT_RST;
            nxt_rx_sr   = CMD_RST;
        end

        if (fall_pend_ff) begin
            nxt_ready_n = 1'b0;
        end
        // New result: present bit one now, drop ready a cycle later.
        // A result that was still unread sees ready high for one cycle.
        if (result_valid_i) begin
            nxt_sdo       = result_i[RESULT_W-1];
            nxt_tx_sr     = {result_i[RESULT_W-2:0], 1'b0};
            nxt_ready_n   = 1'b1;
            nxt_fall_pend = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sclk_q_ff    <= 1'b0;
            sel_n_q_ff   <= 1'b1;
            tx_sr_ff     <= RESULT_RST;
            sdo_ff       <= 1'b0;
            oe_n_ff      <= 1'b1;
            rx_sr_ff     <= CMD_RST;
            bit_cnt_ff   <= BITCNT_RST;
            rx_data_ff   <= CMD_RST;
            rx_valid_ff  <= 1'b0;
            ready_n_ff   <= 1'b1;
            fall_pend_ff <= 1'b0;
            run_ff       <= 1'b0;
        end else begin
            sclk_q_ff    <= pins_i.sclk;
            sel_n_q_ff   <= pins_i.sel_n;
            tx_sr_ff     <= nxt_tx_sr;
            sdo_ff       <= nxt_sdo;
            oe_n_ff      <= nxt_oe_n;
            rx_sr_ff     <= nxt_rx_sr;
            bit_cnt_ff   <= nxt_bit_cnt;
            rx_data_ff   <= nxt_rx_data;
            rx_valid_ff  <= nxt_rx_valid;
            ready_n_ff   <= nxt_ready_n;
            fall_pend_ff <= nxt_fall_pend;
            run_ff       <= start_i;
        end
    end

    assign pins_o           = '{sdo: sdo_ff, sdo_oe_n: oe_n_ff};
    assign result_ready_n_o = ready_n_ff;
    assign rx_data_o        = rx_data_ff;
    assign rx_valid_o       = rx_valid_ff;
    assign conv_run_o       = run_ff;

    chk_rise_sample: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rise_edge && !stall && bit_cnt_ff == BITCNT_TOP
        |=> rx_valid_o && rx_data_o[0] == $past(pins_i.sdi))
        else $error("input bit not taken on rising serial clock");

    chk_fall_shift: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        fall_edge && !result_valid_i |=> pins_o.sdo == $past(tx_sr_ff[RESULT_W-1]))
        else $error("output bit not advanced on falling serial clock");

    chk_select_drive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !pins_i.sel_n |=> !pins_o.sdo_oe_n)
        else $error("selected device not driving its data output");

    chk_release_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pins_i.sel_n && !sel_n_q_ff |-> ##[1:rel_bound] pins_o.sdo_oe_n)
        else $error("data output not released after deselect");

    chk_stall_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        stall |=> bit_cnt_ff == BITCNT_RST && rx_sr_ff == CMD_RST)
        else $error("stall did not clear shift state");

    chk_ready_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        result_valid_i ##1 !result_valid_i |=> !result_ready_n_o)
        else $error("ready not driven low after new result");

    chk_ready_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        result_valid_i && !result_ready_n_o |=> result_ready_n_o)
        else $error("unread result did not pulse ready high");

    chk_first_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(result_ready_n_o) && !$past(fall_edge)
        |-> $past(pins_o.sdo) == $past(result_i[RESULT_W-1], 2))
        else $error("first result bit not ready before ready fell");

    chk_start_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        start_i ##1 start_i |=> conv_run_o)
        else $error("high start input did not run conversions");

    chk_reset_state: assert property (@(posedge clk_i)
        !rst_n_i |=> result_ready_n_o && pins_o.sdo_oe_n && bit_cnt_ff == BITCNT_RST)
        else $error("reset did not restore idle state");

    chk_deselect_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pins_i.sel_n |=> $stable(bit_cnt_ff) && $stable(rx_sr_ff))
        else $error("shift state changed while deselected");

endmodule // adc_serial_port

// [adc_port_pkg.sv]
package adc_port_pkg;

    // Clock rates: the block clock is the converter master clock
    localparam int CLK_PERIOD_NS    = 100;
    localparam int MASTER_PERIOD_NS = 100;

    // Widths
    localparam int RESULT_W = 24;
    localparam int CMD_W    = 8;
    localparam int BITCNT_W = 3;
    localparam int TMR_W    = 13;

    // Serial clock stall timeout, in master clock periods
    localparam int STALL_LONG_PERIODS  = 4096;
    localparam int STALL_SHORT_PERIODS = 256;
    localparam int STALL_LONG_CYC      = STALL_LONG_PERIODS * MASTER_PERIOD_NS / CLK_PERIOD_NS;
    localparam int STALL_SHORT_CYC     = STALL_SHORT_PERIODS * MASTER_PERIOD_NS / CLK_PERIOD_NS;

    // Output release after deselect, longest time in master clock periods
    localparam int RELEASE_PERIODS = 5;
    localparam int RELEASE_CYC     = RELEASE_PERIODS * MASTER_PERIOD_NS / CLK_PERIOD_NS;

    // Reset values and the last bit count of a byte
    localparam logic [BITCNT_W-1:0] BITCNT_RST = 3'h0;
    localparam logic [BITCNT_W-1:0] BITCNT_TOP = 3'h7;
    localparam logic [RESULT_W-1:0] RESULT_RST = 24'h00_0000;
    localparam logic [CMD_W-1:0]    CMD_RST    = 8'h00;
    localparam logic [TMR_W-1:0]    TMR_RST    = 13'h0000;

    // Serial pins driven by the host
    typedef struct packed {
        logic sclk;
        logic sdi;
        logic sel_n;
    } spi_in_s;

    // Serial data output with its enable (low = driving)
    typedef struct packed {
        logic sdo;
        logic sdo_oe_n;
    } spi_out_s;

endpackage

// [sclk_stall_timer.sv]
`timescale 1ns/1ps

module sclk_stall_timer
    import adc_port_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Control
    input  wire logic armed_i,
    input  wire logic sclk_edge_i,
    input  wire logic short_i,
    // Result
    output logic      expire_o
);

    logic [TMR_W-1:0] cnt_ff;
    logic [TMR_W-1:0] nxt_cnt;
    logic [TMR_W-1:0] limit;

    always_comb begin
        limit   = short_i ? TMR_W'(STALL_SHORT_CYC) : TMR_W'(STALL_LONG_CYC);
        nxt_cnt = cnt_ff;
        if (!armed_i || sclk_edge_i || expire_o) begin
            nxt_cnt = TMR_RST;
        end else begin
            nxt_cnt = cnt_ff + TMR_W'(1);
        end
    end

    // Fires once the level has held for more than the limit
    assign expire_o = armed_i && !sclk_edge_i && (cnt_ff == limit);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_ff <= TMR_RST;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    chk_timer_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cnt_ff <= limit)
        else $error("stall timer ran past its limit");

endmodule // sclk_stall_timer

// [host_model.sv]
`timescale 1ns/1ps

module host_model
    import adc_port_pkg::*;
(
    // Clock
    input  wire logic     clk_i,
    // Serial pins
    output spi_in_s       pins_o,
    input  wire spi_out_s pins_i
);
    // Released data line sinks through its load to ground
    logic sdo_line;
    assign sdo_line = pins_i.sdo_oe_n ? 1'b0 : pins_i.sdo;

    initial pins_o = '{sclk: 1'b0, sdi: 1'b0, sel_n: 1'b1};

    // Select low addresses the device; setup time before the first clock
    task automatic select(input logic on);
        @(posedge clk_i) pins_o.sel_n <= ~on;
        repeat (2) @(posedge clk_i);
    endtask

    // Data moves while the clock is low; readback waits for the shifted output
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            @(posedge clk_i) pins_o.sdi <= tx[i];
            @(posedge clk_i);
            @(posedge clk_i) pins_o.sclk <= 1'b1;
            rx[i] = sdo_line;
            repeat (2) @(posedge clk_i);
            pins_o.sclk <= 1'b0;
        end
        // Data input flips after the last bit, while the clock stays low
        @(posedge clk_i) pins_o.sdi <= ~pins_o.sdi;
    endtask

    // Clock and data wiggle while the device is not addressed
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (2) @(posedge clk_i);
            pins_o.sclk <= ~pins_o.sclk;
            pins_o.sdi  <= ~pins_o.sdi;
        end
    endtask
endmodule // host_model

// [tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end

module tb_top;
    import adc_port_pkg::*;

    logic                clk_i           = 1'b0;
    logic                rst_n_i;
    logic                start_i;
    logic                short_timeout_i;
    logic [RESULT_W-1:0] result_i;
    logic                result_valid_i;
    spi_in_s             pins;
    spi_out_s            pins_o;
    logic                conv_run_o;
    logic                result_ready_n_o;
    logic [CMD_W-1:0]    rx_data_o;
    logic                rx_valid_o;
    logic [7:0]          rx;
    int                  miscompares     = 0;
    int                  checks_done     = 0;
    int                  rx_pulses       = 0;

    always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

    // Counted on the falling edge, where the registered pulse has settled
    always @(negedge clk_i) begin
        if (rx_valid_o === 1'b1) begin
            rx_pulses++;
        end
    end

    adc_serial_port DUT (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .pins_i(pins), .pins_o(pins_o),
        .start_i(start_i), .short_timeout_i(short_timeout_i), .conv_run_o(conv_run_o),
        .result_i(result_i), .result_valid_i(result_valid_i),
        .result_ready_n_o(result_ready_n_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o)
    );

    host_model u_host (.clk_i(clk_i), .pins_o(pins), .pins_i(pins_o));

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic pulse(input logic [RESULT_W-1:0] v);
        @(posedge clk_i) result_i <= v;
        result_valid_i <= 1'b1;
        @(posedge clk_i) result_valid_i <= 1'b0;
    endtask

    // Called just after a clock edge: two edges see reset low
    task automatic t_reset();
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1 `CHK(pins_o.sdo_oe_n, 1'b1)
        `CHK(result_ready_n_o, 1'b1)
        `CHK(conv_run_o, 1'b0)
        `CHK(rx_data_o, 8'h00)
        $display("test reset done");
    endtask

    task automatic t_start();
        @(posedge clk_i) start_i <= 1'b1;
        #1 `CHK(conv_run_o, 1'b0)
        @(posedge clk_i) start_i <= 1'b0;
        #1 `CHK(conv_run_o, 1'b1)
        @(posedge clk_i) #1 `CHK(conv_run_o, 1'b0)
        $display("test start done");
    endtask

    task automatic t_read();
        logic [23:0] res;
        logic [23:0] tx;
        int          p0;
        res = 24'hA5_3C96;
        tx  = 24'hC3_5A0F;
        p0  = rx_pulses;
        pulse(res);
        repeat (3) @(posedge clk_i);
        #1 `CHK(result_ready_n_o, 1'b0)
        u_host.select(1'b1);
        #1 `CHK(pins_o.sdo_oe_n, 1'b0)
        `CHK(pins_o.sdo, res[23])
        for (int b = 2; b >= 0; b--) begin
            u_host.xfer(tx[b*8 +: 8], 8, rx);
            `CHK(rx, res[b*8 +: 8])
            `CHK(rx_data_o, tx[b*8 +: 8])
        end
        `CHK(rx_pulses - p0, 3)
        u_host.select(1'b0);
        repeat (3) @(posedge clk_i);
        #1 `CHK(pins_o.sdo_oe_n, 1'b1)
        $display("test read done");
    endtask

    task automatic t_unread();
        int n;
        n = 0;
        pulse(24'h12_3456);
        repeat (3) @(posedge clk_i);
        #1 `CHK(result_ready_n_o, 1'b0)
        pulse(24'h65_4321);
        repeat (5) begin
            #1 if (result_ready_n_o === 1'b1) n++;
            @(posedge clk_i);
        end
        `CHK(n, 1)
        $display("test unread done");
    endtask

    task automatic t_ignore();
        u_host.stray(6);
        u_host.select(1'b1);
        u_host.xfer(8'h96, 8, rx);
        `CHK(rx_data_o, 8'h96)
        u_host.select(1'b0);
        $display("test ignore done");
    endtask

    task automatic t_stall();
        u_host.select(1'b1);
        u_host.xfer(8'hFF, 3, rx);
        // Longer than the short timeout while selected and idle
        repeat (STALL_SHORT_CYC + 40) @(posedge clk_i);
        u_host.xfer(8'h3C, 8, rx);
        `CHK(rx_data_o, 8'h3C)
        u_host.select(1'b0);
        $display("test stall done");
    endtask

    // Long limit: a pause past the short limit must keep a partial byte
    task automatic t_stall_long();
        @(posedge clk_i) short_timeout_i <= 1'b0;
        u_host.select(1'b1);
        u_host.xfer(8'hFF, 3, rx);
        repeat (STALL_SHORT_CYC + 40) @(posedge clk_i);
        u_host.xfer(8'h00, 5, rx);
        `CHK(rx_data_o, 8'hE0)
        u_host.xfer(8'hFF, 3, rx);
        repeat (STALL_LONG_CYC + 40) @(posedge clk_i);
        u_host.xfer(8'h3C, 8, rx);
        `CHK(rx_data_o, 8'h3C)
        u_host.select(1'b0);
        @(posedge clk_i) short_timeout_i <= 1'b1;
        $display("test stall long done");
    endtask

    initial begin
        rst_n_i         = 1'b0;
        start_i         = 1'b0;
        short_timeout_i = 1'b1;
        result_i        = 24'h00_0000;
        result_valid_i  = 1'b0;
        t_reset();
        t_start();
        t_read();
        t_unread();
        // Mid-run reset with an unread result and a received byte standing
        t_reset();
        t_ignore();
        t_stall();
        t_stall_long();
        test_done();
    end

    // Whole run needs roughly 5100 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        test_done();
    end
endmodule // tb_top
